// ==== verilog/mem_cfg_pkg.sv ====
// Constants and types shared by the memory configuration block.
// Summary of operation
// - Read-enable bit n set: reads in 16 KB segment n come from local DRAM.
// - Write-enable bit n set: writes in segment n land in local DRAM.
// - Segments ascend by 16 KB from C0000H; bit 15 ends at FFFFFH.
// - All shadow read and write enables reset to zero.
// - Bank control bits 7:0 hold start address bits 27:20.
// - Size field 11:9: 000 is 1 MB, doubling to 110 for 64 MB.
// - Column field 14:12: 000 is 8 bits, up to 100 for 12 bits.
// - Bits 8 and 15 reserved; all bank fields reset to zero.
// - Bank one control uses the same layout as bank zero.
// - Bank one decodes with the same encodings through the same decoder.
package mem_cfg_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   // Printed offsets are indices; byte address is four times the index.
   localparam logic [11:0] SHADOW_READ_IDX  = 12'h200;
   localparam logic [11:0] SHADOW_WRITE_IDX = 12'h201;
   localparam logic [11:0] BANK_ZERO_IDX    = 12'h202;
   localparam logic [11:0] BANK_ONE_IDX     = 12'h203;
   localparam logic [13:0] SHADOW_READ_ADDR  = {SHADOW_READ_IDX, 2'b00};
   localparam logic [13:0] SHADOW_WRITE_ADDR = {SHADOW_WRITE_IDX, 2'b00};
   localparam logic [13:0] BANK_ZERO_ADDR    = {BANK_ZERO_IDX, 2'b00};
   localparam logic [13:0] BANK_ONE_ADDR     = {BANK_ONE_IDX, 2'b00};

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int START_LSB = 0;
   localparam int START_W   = 8;
   localparam int SIZE_LSB  = 9;
   localparam int SIZE_W    = 3;
   localparam int COL_LSB   = 12;
   localparam int COL_W     = 3;
   localparam logic [15:0] BANK_WRITE_MASK  = 16'h7eff;
   localparam logic [15:0] SHADOW_RESET     = 16'h0000;
   localparam logic [15:0] BANK_RESET       = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Address space
   // ----------------------------------------------------------------
   localparam int          MEM_ADDR_W     = 28;
   localparam int          MB_SHIFT       = 20;
   localparam logic [19:0] SHADOW_BASE    = 20'hc0000;
   localparam int          SEG_SHIFT      = 14;
   localparam int          SEG_COUNT      = 16;
   localparam logic [3:0]  COL_BASE_BITS  = 4'h8;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_t;

endpackage : mem_cfg_pkg

// ==== verilog/bank_decode.sv ====
// Decoder turning one bank control word into start, limit and hit.
`timescale 1ns/10ps
module bank_decode
   import mem_cfg_pkg::*;
(
   input  wire logic [15:0]           ctrl,
   input  wire logic [MEM_ADDR_W-1:0] addr,
   output logic      [MEM_ADDR_W:0]   limit,
   output logic      [3:0]            col_bits,
   output logic                       hit
);
   logic [MEM_ADDR_W:0] start;
   logic [MEM_ADDR_W:0] size;
   logic [SIZE_W-1:0]   size_code;

   assign size_code = ctrl[SIZE_LSB +: SIZE_W];
   // Start address granularity of 1 MB.
   assign start = {1'b0, ctrl[START_LSB +: START_W],
                   20'h00000};
   // One megabyte shifted left by the size code.
   assign size  = (MEM_ADDR_W+1)'(1) << (MB_SHIFT + int'(size_code));
   assign limit = start + size;
   assign col_bits = COL_BASE_BITS + {1'b0, ctrl[COL_LSB +: COL_W]};
   assign hit = ({1'b0, addr} >= start) &&
                ({1'b0, addr} < limit);
endmodule : bank_decode

// ==== verilog/mem_cfg.sv ====
// Shadow RAM enables and bank 0/1 decode registers behind Avalon-MM.
`timescale 1ns/10ps
module mem_cfg
   import mem_cfg_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire logic [13:0]            avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic      [31:0]            avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   mem_valid,
   input  wire logic                   mem_is_write,
   input  wire logic [MEM_ADDR_W-1:0]  mem_addr,
   output logic                        local_dram_q,
   output logic                        bank_zero_hit_q,
   output logic                        bank_one_hit_q,
   output logic      [3:0]             col_width_q
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [15:0]  shadow_read_enable_q;
   logic [15:0]  shadow_write_enable_q;
   logic [15:0]  bank_zero_control_q;
   logic [15:0]  bank_one_control_q;
   logic [31:0]  readdata_q;
   bus_state_t   state_q;
   bus_state_t   state_d;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Every access is held one cycle by waitrequest so read data comes
   // from a flop; the cost is one extra cycle on each transfer.
   wire        req        = avs_read | avs_write;
   wire        take       = req && (state_q == BUS_ACK);
   wire        wr_take    = take && avs_write;
   wire        sel_sr     = (avs_address == SHADOW_READ_ADDR);
   wire        sel_sw     = (avs_address == SHADOW_WRITE_ADDR);
   wire        sel_b0     = (avs_address == BANK_ZERO_ADDR);
   wire        sel_b1     = (avs_address == BANK_ONE_ADDR);
   wire [15:0] lane_mask  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [15:0] wdata      = avs_writedata[15:0];

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [15:0] val,
                                         input logic [15:0] mask);
      merge = (old & ~mask) | (val & mask);
   endfunction : merge

   wire [15:0] sr_d = merge(shadow_read_enable_q, wdata, lane_mask);
   wire [15:0] sw_d = merge(shadow_write_enable_q, wdata, lane_mask);
   // Reserved bits 8 and 15 stay zero whatever software writes.
   wire [15:0] b0_d = merge(bank_zero_control_q, wdata,
                            lane_mask & BANK_WRITE_MASK);
   wire [15:0] b1_d = merge(bank_one_control_q, wdata,
                            lane_mask & BANK_WRITE_MASK);

   wire [15:0] rd_sel = sel_sr ? shadow_read_enable_q  :
                        sel_sw ? shadow_write_enable_q :
                        sel_b0 ? bank_zero_control_q   :
                        sel_b1 ? bank_one_control_q    : 16'h0000;
   wire [31:0] rd_word = {16'h0000, rd_sel} | UNMAPPED_READ;

   always_comb begin
      case (state_q)
         BUS_IDLE: state_d = req ? BUS_ACK : BUS_IDLE;
         BUS_ACK:  state_d = BUS_IDLE;
         default:  state_d = BUS_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Bus handshake and read data
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q         <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
         readdata_q      <= 32'h0000_0000;
      end else begin
         state_q         <= state_d;
         avs_waitrequest <= !(req && state_q == BUS_IDLE);
         if (req && state_q == BUS_IDLE && avs_read) begin
            readdata_q <= rd_word;
         end
      end
   end
   assign avs_readdata = readdata_q;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shadow_read_enable_q  <= SHADOW_RESET;
         shadow_write_enable_q <= SHADOW_RESET;
         bank_zero_control_q   <= BANK_RESET;
         bank_one_control_q    <= BANK_RESET;
      end else if (wr_take) begin
         if (sel_sr) shadow_read_enable_q  <= sr_d;
         if (sel_sw) shadow_write_enable_q <= sw_d;
         if (sel_b0) bank_zero_control_q   <= b0_d;
         if (sel_b1) bank_one_control_q    <= b1_d;
      end
   end

   // ----------------------------------------------------------------
   // Shadow region steering
   // ----------------------------------------------------------------
   wire        in_shadow = (mem_addr[MEM_ADDR_W-1:20] == '0) &&
                           (mem_addr[19:18] == SHADOW_BASE[19:18]);
   wire [3:0]  seg_idx   = mem_addr[SEG_SHIFT +: 4];
   wire [15:0] seg_read_en  = shadow_read_enable_q;
   wire [15:0] seg_write_en = shadow_write_enable_q;
   logic [SEG_COUNT-1:0] seg_allow;

   genvar g;
   generate
      for (g = 0; g < SEG_COUNT; g++) begin : g_seg
         // Read and write enables act independently per segment.
         assign seg_allow[g] = mem_is_write ? seg_write_en[g]
                                            : seg_read_en[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Bank decode
   // ----------------------------------------------------------------
   logic [3:0]  col0;
   logic [3:0]  col1;
   logic        hit0;
   logic        hit1;

   bank_decode u_bank_zero (
      .ctrl     (bank_zero_control_q),
      .addr     (mem_addr),
      .limit    (),
      .col_bits (col0),
      .hit      (hit0)
   );

   // Same decoder for bank one keeps the encodings identical.
   bank_decode u_bank_one (
      .ctrl     (bank_one_control_q),
      .addr     (mem_addr),
      .limit    (),
      .col_bits (col1),
      .hit      (hit1)
   );

   // Shadow region overrides bank decode: disabled segments go elsewhere.
   wire dram_d = in_shadow ? seg_allow[seg_idx] : (hit0 | hit1);

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         local_dram_q    <= 1'b0;
         bank_zero_hit_q <= 1'b0;
         bank_one_hit_q  <= 1'b0;
         col_width_q     <= 4'h0;
      end else begin
         local_dram_q    <= mem_valid && dram_d;
         bank_zero_hit_q <= mem_valid && hit0;
         bank_one_hit_q  <= mem_valid && !hit0 && hit1;
         col_width_q     <= hit0 ? col0 : col1;
      end
   end

endmodule : mem_cfg

// ==== tb/mem_cfg_sva.sv ====
// Port-level assertions for the memory configuration block.
`timescale 1ns/10ps
module mem_cfg_sva
   import mem_cfg_pkg::*;
(
   input wire logic                  sys_clk,
   input wire logic                  sys_rst,
   input wire logic [13:0]           avs_address,
   input wire logic                  avs_read,
   input wire logic                  avs_write,
   input wire logic [31:0]           avs_writedata,
   input wire logic [31:0]           avs_readdata,
   input wire logic                  avs_waitrequest,
   input wire logic                  mem_valid,
   input wire logic                  mem_is_write,
   input wire logic [MEM_ADDR_W-1:0] mem_addr,
   input wire logic                  local_dram_q,
   input wire logic                  bank_zero_hit_q,
   input wire logic                  bank_one_hit_q,
   input wire logic [3:0]            col_width_q
);
   // Shadow enables mirrored from completed bus writes.
   logic [15:0] rd_en_q;
   logic [15:0] wr_en_q;
   wire done_wr = avs_write && !avs_waitrequest;
   wire done_rd = avs_read && !avs_waitrequest;
   wire in_shadow = mem_addr[27:18] == 10'h003;
   wire shadow_en = mem_is_write ? wr_en_q[mem_addr[17:14]]
                                 : rd_en_q[mem_addr[17:14]];
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_en_q <= SHADOW_RESET;
         wr_en_q <= SHADOW_RESET;
      end else if (done_wr && avs_address == SHADOW_READ_ADDR) begin
         rd_en_q <= avs_writedata[15:0];
      end else if (done_wr && avs_address == SHADOW_WRITE_ADDR) begin
         wr_en_q <= avs_writedata[15:0];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_wait_once: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest did not drop");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_upper_zero: assert property (
      done_rd |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_bank_reserved: assert property (
      done_rd && (avs_address == BANK_ZERO_ADDR ||
      avs_address == BANK_ONE_ADDR) |-> !avs_readdata[8] && !avs_readdata[15])
      else $error("reserved bank bit set");
   a_unmapped_zero: assert property (
      done_rd && avs_address > BANK_ONE_ADDR |-> avs_readdata == UNMAPPED_READ)
      else $error("unmapped read not zero");
   a_shadow_path: assert property (
      mem_valid && in_shadow |=> local_dram_q == $past(shadow_en))
      else $error("shadow segment steering wrong");
   a_bank_local: assert property (
      mem_valid && !in_shadow |=>
      local_dram_q == (bank_zero_hit_q || bank_one_hit_q))
      else $error("bank steering wrong");
   a_hit_priority: assert property (
      bank_zero_hit_q |-> !bank_one_hit_q)
      else $error("both banks hit");
   a_col_legal: assert property (
      bank_zero_hit_q || bank_one_hit_q |-> col_width_q inside {[8:12]})
      else $error("column width out of range");
endmodule : mem_cfg_sva
bind mem_cfg mem_cfg_sva i_mem_cfg_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .mem_valid(mem_valid),
   .mem_is_write(mem_is_write), .mem_addr(mem_addr),
   .local_dram_q(local_dram_q), .bank_zero_hit_q(bank_zero_hit_q),
   .bank_one_hit_q(bank_one_hit_q), .col_width_q(col_width_q));

// ==== tb/mem_master_model.sv ====
// Processor or PCI master issuing single memory cycles.
`timescale 1ns/10ps
module mem_master_model
   import mem_cfg_pkg::*;
(
   input  wire logic                  sys_clk,
   output logic                       mem_valid,
   output logic                       mem_is_write,
   output logic      [MEM_ADDR_W-1:0] mem_addr
);
   initial begin
      mem_valid = 1'b0;
      mem_is_write = 1'b0;
      mem_addr = '0;
   end
   task automatic access(input logic [MEM_ADDR_W-1:0] a, input logic wr);
      @(posedge sys_clk);
      mem_valid <= 1'b1;
      mem_is_write <= wr;
      mem_addr <= a;
      @(posedge sys_clk);
      // Released lines show the inverse so a stale value cannot pass.
      mem_valid <= 1'b0;
      mem_is_write <= ~wr;
      mem_addr <= ~a;
   endtask : access
endmodule : mem_master_model

// ==== tb/mem_cfg_bench.sv ====
// Self-checking bench for the memory configuration block.
`timescale 1ns/10ps
module mem_cfg_bench;
   import mem_cfg_pkg::*;
   logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic mem_valid, mem_is_write, local_dram_q, bank_zero_hit_q;
   logic bank_one_hit_q;
   logic [13:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, col_width_q;
   logic [MEM_ADDR_W-1:0] mem_addr;
   logic [15:0] rdata;
   int n_errors = 0;
   int check_count = 0;
   // Address, write flag, then local, bank 0, bank 1 and column width.
   logic [35:0] rows [12] = '{36'h00c0000_49, 36'h00c0000_89,
      36'h00c4000_c9, 36'h00c7fff_09, 36'h00fffff_49, 36'h00fc000_89,
      36'h1000000_6c, 36'h13fffff_ec, 36'h1400000_59, 36'h14fffff_59,
      36'h1500000_09, 36'h0ffffff_09};
   mem_cfg i_mem_cfg (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mem_valid(mem_valid), .mem_is_write(mem_is_write),
      .mem_addr(mem_addr), .local_dram_q(local_dram_q),
      .bank_zero_hit_q(bank_zero_hit_q), .bank_one_hit_q(bank_one_hit_q),
      .col_width_q(col_width_q));
   mem_master_model i_mem_master_model (.sys_clk(sys_clk),
      .mem_valid(mem_valid), .mem_is_write(mem_is_write),
      .mem_addr(mem_addr));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task final_report;
      if (n_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task bus(input logic wr, input logic [13:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata[15:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task mem(input logic [35:0] r);
      i_mem_master_model.access(r[35:8], r[7]);
      #1;
      check({9'h0, local_dram_q, bank_zero_hit_q, bank_one_hit_q, col_width_q},
            {9'h0, r[6:0]});
   endtask : mem
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      final_report();
   end
   initial begin
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      avs_byteenable = 4'hf;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      bus(1'b1, SHADOW_READ_ADDR, 16'h8001);
      bus(1'b1, SHADOW_WRITE_ADDR, 16'h0002);
      bus(1'b1, BANK_ZERO_ADDR, 16'hc510);
      bus(1'b1, BANK_ONE_ADDR, 16'h1014);
      foreach (rows[i]) mem(rows[i]);
      bus(1'b0, BANK_ZERO_ADDR, 16'h0000);
      check(rdata, 16'h4410);
      bus(1'b0, BANK_ONE_ADDR, 16'h0000);
      check(rdata, 16'h1014);
      bus(1'b0, SHADOW_READ_ADDR, 16'h0000);
      check(rdata, 16'h8001);
      bus(1'b0, SHADOW_WRITE_ADDR, 16'h0000);
      check(rdata, 16'h0002);
      bus(1'b1, 14'h0810, 16'hffff);
      bus(1'b0, 14'h0810, 16'h0000);
      check(rdata, 16'h0000);
      bus(1'b1, BANK_ONE_ADDR, 16'h00ff);
      for (int c = 0; c < 7; c++) begin
         bus(1'b1, BANK_ZERO_ADDR, 16'((c << 9) | ((c % 5) << 12)));
         i_mem_master_model.access(28'((32'h0010_0000 << c) - 1), 1'b0);
         #1;
         check({11'h0, bank_zero_hit_q, col_width_q},
               {11'h0, 1'b1, 4'(8 + c % 5)});
         i_mem_master_model.access(28'(32'h0010_0000 << c), 1'b0);
         #1;
         check({15'h0, bank_zero_hit_q}, 16'h0000);
      end
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 4; a++) begin
         bus(1'b0, SHADOW_READ_ADDR + 14'(4 * a), 16'h0000);
         check(rdata, 16'h0000);
      end
      // Upper lane only: low byte must keep its reset value.
      avs_byteenable <= 4'h2;
      bus(1'b1, BANK_ONE_ADDR, 16'hbbff);
      avs_byteenable <= 4'hf;
      bus(1'b0, BANK_ONE_ADDR, 16'h0000);
      check(rdata, 16'h3a00);
      mem(36'h00c0000_28);
      mem(36'h00c0000_a8);
      final_report();
   end
endmodule : mem_cfg_bench
